/* File: design/charge_monitor_consts.vh */
// constants for the battery threshold and alert logic
`ifndef CHARGE_MONITOR_CONSTS_VH
`define CHARGE_MONITOR_CONSTS_VH

// widths of readings and configured levels
`define CAP_W 16
`define MV_W 16
`define PCT_W 7
// load model encodings
`define LOAD_MODEL_CURRENT 1'b0
`define LOAD_MODEL_POWER 1'b1
// control state word bit positions
`define CTRL_LOAD_MODEL_BIT 0
`define CTRL_READY_BIT 1
// flag word bit positions
`define FLAG_LOW_CAP_BIT 0
`define FLAG_SHUTDOWN_BIT 1
`define FLAG_EMPTY_BIT 2
// full charge value of the percentage
`define PCT_FULL 7'h64
// length of the charge-alert pulse in ns, and cycles at 100 MHz
`define ALERT_PULSE_NS 100
`define CLK_PERIOD_NS 10
`define ALERT_PULSE_CYC (`ALERT_PULSE_NS / `CLK_PERIOD_NS)

`endif

/* File: design/level_compare.v */
// hysteresis flag: set below one level, clear above another
`timescale 1ns/10ps
`default_nettype none

module level_compare #(
  parameter W = 16
) (
  input wire clk,
  input wire reset_n,
  input wire update,
  input wire [W-1:0] reading,
  input wire [W-1:0] set_level,
  input wire [W-1:0] clear_level,
  output reg flag,
  output reg changed
);

  // flag only moves on an update strobe so it stays coherent with the latest reading
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag <= 1'b0;
      changed <= 1'b0;
    end else begin
      changed <= 1'b0;
      if (update) begin
        if (!flag && (reading < set_level)) begin
          flag <= 1'b1;
          changed <= 1'b1;
        end else if (flag && (reading > clear_level)) begin
          // clear needs the flag already set
          flag <= 1'b0;
          changed <= 1'b1;
        end
      end
    end
  end

endmodule

`default_nettype wire

/* File: design/charge_integrator.v */
// coulomb counter: integrates signed charge steps into a remaining-charge value
`timescale 1ns/10ps
`default_nettype none

module charge_integrator #(
  parameter W = 16
) (
  input wire clk,
  input wire reset_n,
  input wire load,
  input wire [W-1:0] load_value,
  input wire step,
  input wire signed [W-1:0] delta,
  input wire [W-1:0] limit,
  output reg [W-1:0] charge
);

  reg signed [W+1:0] sum; // wide enough for overflow either side

  // sum of present charge and step, before clamping
  always @* begin
    sum = $signed({2'b00, charge}) + {{2{delta[W-1]}}, delta};
  end

  // clamp to zero and the full limit; never wraps
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      charge <= {W{1'b0}};
    end else if (load) begin
      charge <= load_value;
    end else if (step) begin
      if (sum[W+1]) begin
        charge <= {W{1'b0}};
      end else if (sum > $signed({2'b00, limit})) begin
        charge <= limit;
      end else begin
        charge <= sum[W-1:0];
      end
    end
  end

endmodule

`default_nettype wire

/* File: design/battery_threshold_alert_logic.v */
// threshold, alert and charge bookkeeping logic of the battery monitor
`include "charge_monitor_consts.vh"
`timescale 1ns/10ps
`default_nettype none

module battery_threshold_alert_logic #(
  parameter CAP_W = `CAP_W,
  parameter MV_W = `MV_W,
  parameter ALERT_CYC = `ALERT_PULSE_CYC
) (
  input wire clk,
  input wire rst_n,
  input wire measure_update,
  input wire [MV_W-1:0] cell_mv,
  input wire charge_step,
  input wire [CAP_W-1:0] charge_delta,
  input wire capacity_load,
  input wire [CAP_W-1:0] capacity_load_value,
  input wire [CAP_W-1:0] full_capacity_in,
  input wire [CAP_W-1:0] low_capacity_set_level,
  input wire [MV_W-1:0] shutdown_set_level,
  input wire [MV_W-1:0] shutdown_clear_level,
  input wire [MV_W-1:0] zero_charge_level,
  input wire [MV_W-1:0] end_discharge_level,
  input wire low_pin_enable,
  input wire load_model_select,
  output reg [CAP_W-1:0] remaining_charge_reading,
  output reg [CAP_W-1:0] full_capacity_estimate,
  output reg [`PCT_W-1:0] charge_percent,
  output reg low_capacity_flag,
  output reg shutdown_warning_flag,
  output reg [2:0] flag_word,
  output reg [1:0] control_state_word,
  output reg battery_low_pin,
  output reg charge_alert,
  output reg load_model_status_bit
);

  // reset release through two flops
  reg rst_meta;
  reg reset_n;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      reset_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      reset_n <= rst_meta;
    end
  end

  // charge percentage of remaining over full, saturated at the full value
  function [`PCT_W-1:0] percent_of;
    input [CAP_W-1:0] part;
    input [CAP_W-1:0] whole;
    reg [CAP_W+7:0] scaled;
    reg [CAP_W+7:0] quot; // full-width quotient, cut to the percent width below
    begin
      scaled = {8'h00, part} * 8'd100;
      quot = scaled / {8'h00, whole};
      if (whole == {CAP_W{1'b0}}) begin
        percent_of = {`PCT_W{1'b0}};
      end else if (part >= whole) begin
        percent_of = `PCT_FULL;
      end else begin
        // part below whole keeps the quotient under 100, so the cut is safe
        percent_of = quot[`PCT_W-1:0];
      end
    end
  endfunction

  // sampled-per-update copy of the voltage reading so all checks see one value
  reg [MV_W-1:0] cell_mv_held;
  reg update_d; // comparisons run one cycle after the strobe
  wire [CAP_W-1:0] charge_now;
  wire low_cap_raw;
  wire low_cap_chg;
  wire shut_raw;
  wire shut_chg;
  reg [CAP_W-1:0] full_hold; // last full capacity estimate above end voltage
  reg [7:0] alert_cnt; // cycles left of the alert pulse
  reg zero_hit; // zero-charge level reached on last update

  // hold the reading at each update
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cell_mv_held <= {MV_W{1'b0}};
      update_d <= 1'b0;
    end else begin
      update_d <= measure_update;
      if (measure_update) begin
        cell_mv_held <= cell_mv;
      end
    end
  end

  // zero-charge detection: at or below the level the integrator is loaded with zero
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      zero_hit <= 1'b0;
    end else if (update_d) begin
      zero_hit <= (cell_mv_held <= zero_charge_level);
    end
  end

  // coulomb counter; a zero-charge hit takes priority over a host load
  charge_integrator #(
    .W(CAP_W)
  ) u_integrator (
    .clk(clk),
    .reset_n(reset_n),
    .load(capacity_load || (update_d && (cell_mv_held <= zero_charge_level))),
    .load_value((update_d && (cell_mv_held <= zero_charge_level)) ? {CAP_W{1'b0}} : capacity_load_value),
    .step(charge_step),
    .delta(charge_delta),
    .limit(full_hold),
    .charge(charge_now)
  );

  // low-capacity flag: same level sets and clears
  level_compare #(
    .W(CAP_W)
  ) u_low_cap (
    .clk(clk),
    .reset_n(reset_n),
    .update(update_d),
    .reading(charge_now),
    .set_level(low_capacity_set_level),
    .clear_level(low_capacity_set_level),
    .flag(low_cap_raw),
    .changed(low_cap_chg)
  );

  // shutdown warning flag with separate clear voltage
  level_compare #(
    .W(MV_W)
  ) u_shutdown (
    .clk(clk),
    .reset_n(reset_n),
    .update(update_d),
    .reading(cell_mv_held),
    .set_level(shutdown_set_level),
    .clear_level(shutdown_clear_level),
    .flag(shut_raw),
    .changed(shut_chg)
  );

  // full capacity is tracked only while the cell is above its end voltage
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      full_hold <= {CAP_W{1'b1}};
    end else if (update_d && (cell_mv_held > end_discharge_level)) begin
      full_hold <= full_capacity_in;
    end
  end

  // alert pulse counter; a new change restarts it, so a change during a pulse extends that pulse
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      alert_cnt <= 8'h00;
    end else if (shut_chg) begin
      alert_cnt <= ALERT_CYC[7:0];
    end else if (alert_cnt != 8'h00) begin
      alert_cnt <= alert_cnt - 8'h01;
    end
  end

  // registered outputs
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      remaining_charge_reading <= {CAP_W{1'b0}};
      full_capacity_estimate <= {CAP_W{1'b0}};
      charge_percent <= {`PCT_W{1'b0}};
      low_capacity_flag <= 1'b0;
      shutdown_warning_flag <= 1'b0;
      flag_word <= 3'h0;
      control_state_word <= 2'h0;
      battery_low_pin <= 1'b0;
      charge_alert <= 1'b0;
      load_model_status_bit <= `LOAD_MODEL_CURRENT;
    end else begin
      remaining_charge_reading <= charge_now;
      full_capacity_estimate <= full_hold;
      // percent forced to zero at the zero-charge level even if counter lags
      charge_percent <= zero_hit ? {`PCT_W{1'b0}} : percent_of(charge_now, full_hold);
      low_capacity_flag <= low_cap_raw;
      shutdown_warning_flag <= shut_raw;
      flag_word[`FLAG_LOW_CAP_BIT] <= low_cap_raw;
      flag_word[`FLAG_SHUTDOWN_BIT] <= shut_raw;
      flag_word[`FLAG_EMPTY_BIT] <= zero_hit;
      // pin mirrors the flag only when enabled; no host write needed
      battery_low_pin <= low_cap_raw & low_pin_enable;
      charge_alert <= shut_chg || (alert_cnt > 8'h01);
      load_model_status_bit <= load_model_select;
      control_state_word[`CTRL_LOAD_MODEL_BIT] <= load_model_select;
      control_state_word[`CTRL_READY_BIT] <= 1'b1;
    end
  end

endmodule

`default_nettype wire

/* File: sim/battery_threshold_alert_logic_monitor.sv */
// assertion checker for the threshold and alert logic
`timescale 1ns/10ps
`default_nettype none
module alert_monitor (
  input wire logic clk, input wire logic rst_n,
  input wire logic measure_update, input wire logic [15:0] cell_mv,
  input wire logic [15:0] shutdown_set_level, input wire logic [15:0] shutdown_clear_level,
  input wire logic [15:0] zero_charge_level, input wire logic low_pin_enable,
  input wire logic load_model_select, input wire logic [15:0] remaining_charge_reading,
  input wire logic [6:0] charge_percent, input wire logic low_capacity_flag,
  input wire logic shutdown_warning_flag, input wire logic [2:0] flag_word,
  input wire logic [1:0] control_state_word, input wire logic battery_low_pin,
  input wire logic charge_alert, input wire logic load_model_status_bit
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // an update that crosses a shutdown level: a drop seen while the flag is clear, a rise while it stands
  sequence drop_seen;
    measure_update && cell_mv < shutdown_set_level && !shutdown_warning_flag;
  endsequence
  sequence rise_seen;
    measure_update && cell_mv > shutdown_clear_level && shutdown_warning_flag;
  endsequence
  shut_set_a: assert property (drop_seen |-> ##3 shutdown_warning_flag && charge_alert)
    else $error("shutdown flag not set");
  shut_clear_a: assert property (rise_seen |-> ##3 !shutdown_warning_flag && charge_alert)
    else $error("shutdown flag not cleared");
  alert_cause_a: assert property ($rose(charge_alert) |-> $changed(shutdown_warning_flag))
    else $error("alert without flag change");
  alert_hold_a: assert property ($rose(charge_alert) |-> charge_alert [*8])
    else $error("alert pulse too short");
  flag_update_a: assert property ($changed(shutdown_warning_flag) |-> $past(measure_update, 3))
    else $error("flag moved without update");
  pin_follow_a: assert property (battery_low_pin |-> low_capacity_flag)
    else $error("pin high without flag");
  pin_gate_a: assert property (!low_pin_enable [*3] |-> !battery_low_pin)
    else $error("pin high while disabled");
  word_mirror_a: assert property (flag_word[1:0] == {shutdown_warning_flag, low_capacity_flag})
    else $error("flag word differs");
  model_bit_a: assert property ((control_state_word[1] && $stable(load_model_select)) [*3]
    |-> load_model_status_bit == load_model_select && control_state_word[0] == load_model_select)
    else $error("load model bit wrong");
  zero_force_a: assert property (measure_update && cell_mv <= zero_charge_level
    |-> ##3 remaining_charge_reading == 16'h0000 && charge_percent == 7'h00)
    else $error("charge not forced to zero");
endmodule
bind battery_threshold_alert_logic alert_monitor mon (.*);
`default_nettype wire

/* File: sim/host_reader.sv */
// host model: reads the flag word after each alert
`timescale 1ns/10ps
`default_nettype none
module host_reader (
  input wire logic clk,
  input wire logic charge_alert,
  input wire logic [2:0] flag_word,
  output int alerts_seen,
  output logic [2:0] last_flags
);
  logic seen = 1'b0;
  initial alerts_seen = 0;
  initial last_flags = 3'h0;
  // latch the flags once per alert pulse
  always @(posedge clk) begin
    seen <= charge_alert;
    if (charge_alert && !seen) begin
      alerts_seen <= alerts_seen + 1;
      last_flags <= flag_word;
    end
  end
endmodule
`default_nettype wire

/* File: sim/battery_threshold_alert_logic_tb.sv */
// testbench for the threshold and alert logic
`timescale 1ns/10ps
`default_nettype none
module battery_threshold_alert_logic_tb;
  logic clk = 0, rst_n = 0, measure_update = 0, charge_step = 0, capacity_load = 0;
  logic low_pin_enable = 1, load_model_select = 0;
  logic [15:0] cell_mv = 16'h0FA0, charge_delta = 0, capacity_load_value = 16'h0258;
  logic [15:0] full_capacity_in = 16'h03E8, low_capacity_set_level = 16'h01F4;
  logic [15:0] shutdown_set_level = 16'h0BB8, shutdown_clear_level = 16'h0C80;
  logic [15:0] zero_charge_level = 16'h0AF0, end_discharge_level = 16'h0B54;
  wire [15:0] remaining_charge_reading, full_capacity_estimate;
  wire [6:0] charge_percent;
  wire [2:0] flag_word, last_flags;
  wire [1:0] control_state_word;
  wire low_capacity_flag, shutdown_warning_flag, battery_low_pin, charge_alert, load_model_status_bit;
  int err_total = 0, num_checks = 0, alerts_seen, cap = 600, low = 0, sd = 0, d;
  battery_threshold_alert_logic DUT (.*);
  host_reader host (.clk, .charge_alert, .flag_word, .alerts_seen, .last_flags);
  always #5 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one charge step, reading compared two edges on
  task automatic step(input int v);
    charge_step = 1;
    charge_delta = v[15:0];
    tick(1);
    charge_step = 0;
    cap += v;
    tick(1);
    chk(remaining_charge_reading, cap[15:0]);
  endtask
  // one measurement; the model settles the flags the same way
  task automatic upd(input int v);
    measure_update = 1;
    cell_mv = v[15:0];
    tick(1);
    measure_update = 0;
    if (cap < 500) low = 1;
    if (cap > 500) low = 0;
    if (!sd && v < 3000) sd = 1;
    else if (sd && v > 3200) sd = 0;
    if (v <= 2800) cap = 0;
    tick(2);
    chk(low_capacity_flag, low);
    chk(shutdown_warning_flag, sd);
    chk(battery_low_pin, low & low_pin_enable);
    chk(remaining_charge_reading, cap[15:0]);
  endtask
  task automatic wrap_up;
    if (err_total == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    wrap_up;
  end
  initial begin
    void'($urandom(55));
    tick(10);
    rst_n = 1;
    tick(4);
    chk(control_state_word[1], 1);
    capacity_load = 1;
    tick(1);
    capacity_load = 0;
    tick(1);
    chk(remaining_charge_reading, 16'h0258);
    repeat (6) begin
      d = $urandom_range(40) - 20;
      step(d);
    end
    upd(3500);
    chk(full_capacity_estimate, 16'h03E8);
    step(450 - cap);
    upd(3500);
    low_pin_enable = 0;
    tick(3);
    chk(battery_low_pin, 0);
    low_pin_enable = 1;
    step(60);
    upd(3500);
    upd(2999);
    chk(charge_alert, 1);
    // let the set pulse run out, else the clear pulse merges with it
    tick(12);
    chk(charge_alert, 0);
    upd(3200);
    upd(3201);
    chk(charge_alert, 1);
    tick(12);
    chk(charge_alert, 0);
    chk(alerts_seen, 2);
    chk(last_flags[1], 0);
    upd(2800);
    chk(charge_percent, 0);
    chk(flag_word[2], 1);
    for (int m = 0; m < 2; m++) begin
      load_model_select = m[0];
      tick(4);
      chk(load_model_status_bit, m);
      chk(control_state_word[0], m);
    end
    wrap_up;
  end
endmodule
`default_nettype wire
